// ===== hw/ddr_calib_defines.svh
`ifndef DDR_CALIB_DEFINES_SVH
`define DDR_CALIB_DEFINES_SVH

// Mode register selected by the bank field of a mode-set command
`define MR_SEL_ZERO      3'h0
`define MR_SEL_THREE     3'h3
// Address bit positions
`define MR3_ENABLE_BIT   2
`define MR3_LOC_MSB      1
`define MR0_BURST_MSB    1
`define ADDR_NIBBLE_BIT  2
`define ADDR_AUTOCLOSE   10
`define ADDR_CHOP_BIT    12
`define COL_MSB          9
// Field values
`define BURST_FIXED8     2'h0
`define BURST_ON_FLY     2'h1
`define BURST_FIXED4     2'h2
`define LOC_PATTERN      2'h0
`define CALIB_PATTERN    8'haa
`define POS_LOWER        3'h0
`define POS_UPPER        3'h4
`define PAIRS_EIGHT      2'h3
`define PAIRS_FOUR       2'h1
// Data leaves RL cycles after the command; three cycles go to pipe, load and buffer
`define RL_TAP_OFFSET    6'h3
// Timing
`define CLK_PERIOD_NS    40
`define ROW_PRECHARGE_NS 15
`define PRE_W            4

`endif

// ===== hw/ddr_calib_pkg.sv
package ddr_calib_pkg;

   typedef enum logic [2:0]
   {
      CMD_NOP   = 3'h0,
      CMD_MRS   = 3'h1,
      CMD_ACT   = 3'h2,
      CMD_PRE   = 3'h3,
      CMD_READ  = 3'h4,
      CMD_WRITE = 3'h5
   } cmd_t;

   typedef struct packed
   {
      logic        valid;
      cmd_t        op;
      logic [2:0]  bank;
      logic [13:0] addr;
   } command_t;

   typedef struct packed
   {
      logic valid;
      logic chop;
      logic upper;
   } pend_t;

   typedef enum logic [0:0]
   {
      GEN_IDLE  = 1'b0,
      GEN_BURST = 1'b1
   } gen_state_t;

endpackage

// ===== hw/beat_buffer.sv
`timescale 1ns/10ps
module beat_buffer #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   typedef struct packed
   {
      logic [1:0][WIDTH-1:0] data;
      logic [1:0]            cnt;
   } buf_state_t;

   buf_state_t r;
   buf_state_t next_r;
   logic       push;
   logic       pop;

   assign in_ready_out  = (r.cnt != 2'h2);
   assign out_valid_out = (r.cnt != 2'h0);
   assign out_data_out  = r.data[0];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb
   begin
      next_r = r;
      if (pop)
      begin
         next_r.data[0] = r.data[1];
         next_r.cnt     = r.cnt - 2'h1;
      end
      if (push)
      begin
         next_r.data[next_r.cnt[0]] = in_data_in;
         next_r.cnt                 = next_r.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         r <= '0;
      else
         r <= next_r;
   end

   a_buffer_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      r.cnt != 2'h3) else $error("buffer count beyond two");

endmodule // beat_buffer

// ===== hw/ddr_calib_readout.sv
// Contract
// - Mode three enable, location zero: redirect reads
// - Eight-beat read returns 0,1,0,1,0,1,0,1
// - Chopped read: lower or upper nibble order
// - Order bit 0 is first beat
// - Data starts additive plus column latency
// - Enable cleared returns accesses to array
// - Activate opens bank row until precharge
// - Precharge closes one or all banks
// - Other bank accepted during auto precharge
// - Repeated precharge restarts the precharge time
// - Address bit twelve selects burst length
// - Burst field 00, or 01 with bit12
// - Only reads in readout; autoclose ignored
// - Bit on line zero, others copy
`timescale 1ns/10ps
`include "ddr_calib_defines.svh"
module ddr_calib_readout #(
   parameter int       DEPTH            = 32,
   parameter int       ROW_PRECHARGE_NS = `ROW_PRECHARGE_NS,
   parameter bit       MIRROR           = 1'b1
) (
   input  wire logic                    CLK_IN,
   input  wire logic                    RST_N_IN,
   input  wire ddr_calib_pkg::command_t CMD_IN,
   input  wire logic [4:0]              ADDITIVE_LATENCY_IN,
   input  wire logic [4:0]              COLUMN_LATENCY_IN,
   input  wire logic                    ERROR_CLEAR_IN,
   input  wire logic                    DQ_READY_IN,
   output logic                         DQ_VALID_OUT,
   output logic [15:0]                  DQ_PAIR_OUT,
   output logic                         CALIB_ACTIVE_OUT,
   output logic [7:0]                   BANK_OPEN_OUT,
   output logic [7:0]                   BANK_IDLE_OUT,
   output logic                         PROTOCOL_ERROR_OUT,
   output logic                         ARRAY_REQ_OUT,
   output logic                         ARRAY_WRITE_OUT,
   output logic                         ARRAY_CHOP_OUT,
   output logic [2:0]                   ARRAY_BANK_OUT,
   output logic [13:0]                  ARRAY_ROW_OUT,
   output logic [9:0]                   ARRAY_COL_OUT
);
   localparam int NB  = 8;
   localparam int IW  = $clog2(DEPTH);
   localparam int TRP_RAW = (ROW_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam logic [`PRE_W-1:0] ROW_PRECHARGE_TIME = (TRP_RAW < 1) ? `PRE_W'(1) : `PRE_W'(TRP_RAW);
   localparam logic [7:0] PATTERN = `CALIB_PATTERN;

   typedef struct packed
   {
      logic                            calib_on;
      logic [1:0]                      loc;
      logic [1:0]                      burst_mode;
      logic [NB-1:0]                   open;
      logic [NB-1:0][13:0]             row;
      logic [NB-1:0][`PRE_W-1:0]       pre_cnt;
      ddr_calib_pkg::pend_t [DEPTH-1:0] pipe;
      ddr_calib_pkg::gen_state_t       gen;
      logic [2:0]                      pos;
      logic [1:0]                      left;
      logic                            err;
      logic                            arr_req;
      logic                            arr_wr;
      logic                            arr_chop;
      logic [2:0]                      arr_bank;
      logic [13:0]                     arr_row;
      logic [9:0]                      arr_col;
   } state_t;

   state_t                  r;
   state_t                  next_r;
   ddr_calib_pkg::command_t c;
   logic [5:0]              rl;
   logic [5:0]              tap;
   ddr_calib_pkg::pend_t    tapped;
   logic                    chop;
   logic                    push;
   logic                    buf_ready;
   logic [15:0]             push_data;
   logic                    bit_even;
   logic                    bit_odd;
   logic                    set_err;

   function automatic logic [7:0] beat_byte(input logic b);
      return MIRROR ? {8{b}} : {7'h0, b};
   endfunction

   assign c      = CMD_IN;
   assign rl     = {1'b0, ADDITIVE_LATENCY_IN} + {1'b0, COLUMN_LATENCY_IN};
   assign tap    = rl - `RL_TAP_OFFSET;
   assign tapped = r.pipe[tap[IW-1:0]];
   // Fixed chop, or on-the-fly with bit twelve low; anything else is eight beats
   assign chop = (r.burst_mode == `BURST_FIXED4) ||
                 ((r.burst_mode == `BURST_ON_FLY) && !c.addr[`ADDR_CHOP_BIT]);
   assign push = (r.gen == ddr_calib_pkg::GEN_BURST);
   // Reserved locations keep the burst order but carry no pattern
   assign bit_even = (r.loc == `LOC_PATTERN) && PATTERN[r.pos];
   assign bit_odd  = (r.loc == `LOC_PATTERN) && PATTERN[r.pos + 3'h1];
   assign push_data = {beat_byte(bit_odd), beat_byte(bit_even)};

   always_comb
   begin
      next_r         = r;
      set_err        = 1'b0;
      next_r.arr_req = 1'b0;
      next_r.pipe    = {r.pipe[DEPTH-2:0], 3'h0};
      for (int b = 0; b < NB; b++)
      begin
         if (r.pre_cnt[b] != '0)
            next_r.pre_cnt[b] = r.pre_cnt[b] - `PRE_W'(1);
      end
      if (push && buf_ready)
      begin
         next_r.pos  = r.pos + 3'h2;
         next_r.left = r.left - 2'h1;
         if (r.left == 2'h0)
            next_r.gen = ddr_calib_pkg::GEN_IDLE;
      end
      // A burst ending this cycle lets the next one follow seamlessly
      if (tapped.valid)
      begin
         if (next_r.gen == ddr_calib_pkg::GEN_IDLE)
         begin
            next_r.gen  = ddr_calib_pkg::GEN_BURST;
            next_r.pos  = tapped.upper ? `POS_UPPER : `POS_LOWER;
            next_r.left = tapped.chop ? `PAIRS_FOUR : `PAIRS_EIGHT;
         end
         else
            set_err = 1'b1;
      end
      if (c.valid)
      begin
         case (c.op)
            ddr_calib_pkg::CMD_MRS:
            begin
               if (c.bank == `MR_SEL_THREE)
               begin
                  next_r.calib_on = c.addr[`MR3_ENABLE_BIT];
                  next_r.loc      = c.addr[`MR3_LOC_MSB:0];
               end
               else if (c.bank == `MR_SEL_ZERO)
                  next_r.burst_mode = c.addr[`MR0_BURST_MSB:0];
            end
            ddr_calib_pkg::CMD_ACT:
            begin
               if (r.calib_on || r.open[c.bank] || (r.pre_cnt[c.bank] != '0))
                  set_err = 1'b1;
               else
               begin
                  next_r.open[c.bank] = 1'b1;
                  next_r.row[c.bank]  = c.addr;
               end
            end
            ddr_calib_pkg::CMD_PRE:
            begin
               if (r.calib_on)
                  set_err = 1'b1;
               else
               begin
                  for (int b = 0; b < NB; b++)
                  begin
                     if (c.addr[`ADDR_AUTOCLOSE] || (c.bank == 3'(b)))
                     begin
                        next_r.open[b]    = 1'b0;
                        next_r.pre_cnt[b] = ROW_PRECHARGE_TIME;
                     end
                  end
               end
            end
            ddr_calib_pkg::CMD_READ,
            ddr_calib_pkg::CMD_WRITE:
            begin
               if (r.calib_on)
               begin
                  // Autoclose and bank are ignored here; writes are refused
                  if (c.op == ddr_calib_pkg::CMD_WRITE)
                     set_err = 1'b1;
                  else
                     next_r.pipe[0] = {1'b1, chop, c.addr[`ADDR_NIBBLE_BIT]};
               end
               else if (!r.open[c.bank])
                  set_err = 1'b1;
               else
               begin
                  // Only the addressed bank is touched, others stay usable
                  next_r.arr_req  = 1'b1;
                  next_r.arr_wr   = (c.op == ddr_calib_pkg::CMD_WRITE);
                  next_r.arr_chop = chop;
                  next_r.arr_bank = c.bank;
                  next_r.arr_row  = r.row[c.bank];
                  next_r.arr_col  = c.addr[`COL_MSB:0];
                  if (c.addr[`ADDR_AUTOCLOSE])
                  begin
                     next_r.open[c.bank]    = 1'b0;
                     next_r.pre_cnt[c.bank] = ROW_PRECHARGE_TIME;
                  end
               end
            end
            default:
            begin
               next_r.pipe[0] = next_r.pipe[0];
            end
         endcase
      end
      // A new fault wins over a clear in the same cycle
      if (ERROR_CLEAR_IN)
         next_r.err = 1'b0;
      if (set_err)
         next_r.err = 1'b1;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         r <= '0;
      else
         r <= next_r;
   end

   beat_buffer #(
      .WIDTH (16)
   ) u_beat_buffer (
      .clk_in        (CLK_IN),
      .rst_n_in      (RST_N_IN),
      .in_valid_in   (push),
      .in_ready_out  (buf_ready),
      .in_data_in    (push_data),
      .out_valid_out (DQ_VALID_OUT),
      .out_ready_in  (DQ_READY_IN),
      .out_data_out  (DQ_PAIR_OUT)
   );

   assign CALIB_ACTIVE_OUT   = r.calib_on;
   assign BANK_OPEN_OUT      = r.open;
   assign PROTOCOL_ERROR_OUT = r.err;
   assign ARRAY_REQ_OUT      = r.arr_req;
   assign ARRAY_WRITE_OUT    = r.arr_wr;
   assign ARRAY_CHOP_OUT     = r.arr_chop;
   assign ARRAY_BANK_OUT     = r.arr_bank;
   assign ARRAY_ROW_OUT      = r.arr_row;
   assign ARRAY_COL_OUT      = r.arr_col;
   always_comb
   begin
      for (int b = 0; b < NB; b++)
         BANK_IDLE_OUT[b] = !r.open[b] && (r.pre_cnt[b] == '0);
   end

   sequence s_enable_write;
      c.valid && c.op == ddr_calib_pkg::CMD_MRS && c.bank == `MR_SEL_THREE;
   endsequence
   sequence s_calib_read;
      c.valid && c.op == ddr_calib_pkg::CMD_READ && r.calib_on;
   endsequence

   a_enable_redirect: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_enable_write and c.addr[`MR3_ENABLE_BIT] |=> r.calib_on ##1 !r.arr_req)
      else $error("readout enable not taken");
   a_pattern_pair: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      push && r.loc == `LOC_PATTERN |-> push_data[0] == 1'b0 && push_data[8] == 1'b1)
      else $error("calibration pattern wrong");
   a_upper_nibble: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      tapped.valid && tapped.upper && !push |=> push && r.pos == `POS_UPPER)
      else $error("upper nibble order wrong");
   a_line_mirror: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      push |-> push_data[7:1] == (MIRROR ? {7{push_data[0]}} : 7'h0))
      else $error("data lines one to seven wrong");
   a_read_latency: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_calib_read and !push and rl == 6'h6 |-> !push [*5] ##1 push)
      else $error("calibration data not at read latency");
   a_chop_select: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_calib_read and r.burst_mode == `BURST_ON_FLY |=>
      r.pipe[0].chop == !$past(c.addr[`ADDR_CHOP_BIT]))
      else $error("burst chop select ignored");
   a_fixed_eight: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_calib_read and r.burst_mode == `BURST_FIXED8 |=> !r.pipe[0].chop)
      else $error("fixed eight-beat burst chopped");
   a_activate_row: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      c.valid && c.op == ddr_calib_pkg::CMD_ACT && BANK_IDLE_OUT[c.bank] && !r.calib_on
      |=> r.open[$past(c.bank)] && r.row[$past(c.bank)] == $past(c.addr))
      else $error("activate did not open row");
   a_precharge_all: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      c.valid && c.op == ddr_calib_pkg::CMD_PRE && c.addr[`ADDR_AUTOCLOSE] && !r.calib_on
      |=> r.open == '0 && r.pre_cnt[0] == ROW_PRECHARGE_TIME && r.pre_cnt[7] == ROW_PRECHARGE_TIME)
      else $error("precharge all did not close banks");
   a_no_calib_write: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      c.valid && c.op == ddr_calib_pkg::CMD_WRITE && r.calib_on |=> !r.arr_req && r.err)
      else $error("write accepted during readout");

endmodule // ddr_calib_readout

// ===== dv/ctrl_model.sv
`timescale 1ns/10ps
module ctrl_model #(
   parameter int MODE_WAIT = 4,
   parameter int ROW_WAIT  = 2,
   parameter int RECOVER   = 2
) (
   input  wire logic               clk_in,
   output ddr_calib_pkg::command_t cmd_out,
   output logic                    dq_ready_out
);
   initial
   begin
      cmd_out = '0;
      dq_ready_out = 1'b1;
   end

   // One command cycle, then the bus goes back to no command
   task automatic send(input ddr_calib_pkg::cmd_t op, input logic [2:0] bank,
                       input logic [13:0] addr);
      @(posedge clk_in);
      cmd_out <= '{1'b1, op, bank, addr};
      @(posedge clk_in);
      cmd_out <= '0;
   endtask

   // Caller must be at a rising edge
   task automatic ready(input logic rdy);
      dq_ready_out <= rdy;
   endtask

   task automatic enter();
      send(ddr_calib_pkg::CMD_PRE, 3'h0, 14'h0400);
      repeat (ROW_WAIT) @(posedge clk_in);
      send(ddr_calib_pkg::CMD_MRS, 3'h3, 14'h0004);
      repeat (MODE_WAIT) @(posedge clk_in);
   endtask

   // Other column bits held at zero; bit 2 picks the nibble, bit 12 the length
   task automatic calib_read(input logic chop, input logic upper, input logic close);
      send(ddr_calib_pkg::CMD_READ, 3'h0, {1'b0, ~chop, 1'b0, close, 7'h0, upper, 2'h0});
   endtask

   task automatic leave();
      repeat (RECOVER) @(posedge clk_in);
      send(ddr_calib_pkg::CMD_MRS, 3'h3, 14'h0000);
      repeat (MODE_WAIT) @(posedge clk_in);
   endtask
endmodule // ctrl_model

// ===== dv/ddr_calib_readout_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
      end \
   end
module ddr_calib_readout_tb;
   localparam int AL = 2;
   localparam int CL = 4;
   logic        CLK_IN, RST_N_IN, ERROR_CLEAR_IN, DQ_READY_IN, DQ_VALID_OUT;
   logic        CALIB_ACTIVE_OUT, PROTOCOL_ERROR_OUT, ARRAY_REQ_OUT;
   logic        ARRAY_WRITE_OUT, ARRAY_CHOP_OUT;
   logic [2:0]  ARRAY_BANK_OUT;
   logic [4:0]  ADDITIVE_LATENCY_IN, COLUMN_LATENCY_IN;
   logic [7:0]  BANK_OPEN_OUT, BANK_IDLE_OUT;
   logic [9:0]  ARRAY_COL_OUT;
   logic [13:0] ARRAY_ROW_OUT;
   logic [15:0] DQ_PAIR_OUT;
   int          mismatches, checks_done;
   ddr_calib_pkg::command_t CMD_IN;

   ctrl_model u_ctrl_model (.clk_in(CLK_IN), .cmd_out(CMD_IN), .dq_ready_out(DQ_READY_IN));

   ddr_calib_readout u_ddr_calib_readout (
      .CLK_IN, .RST_N_IN, .CMD_IN, .ADDITIVE_LATENCY_IN, .COLUMN_LATENCY_IN,
      .ERROR_CLEAR_IN, .DQ_READY_IN, .DQ_VALID_OUT, .DQ_PAIR_OUT, .CALIB_ACTIVE_OUT,
      .BANK_OPEN_OUT, .BANK_IDLE_OUT, .PROTOCOL_ERROR_OUT, .ARRAY_REQ_OUT,
      .ARRAY_WRITE_OUT, .ARRAY_CHOP_OUT, .ARRAY_BANK_OUT, .ARRAY_ROW_OUT, .ARRAY_COL_OUT
   );

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmd(input ddr_calib_pkg::cmd_t op, input logic [2:0] bank,
                      input logic [13:0] addr);
      u_ctrl_model.send(op, bank, addr);
      #1;
   endtask

   task automatic clear_err();
      @(posedge CLK_IN);
      ERROR_CLEAR_IN <= 1'b1;
      @(posedge CLK_IN);
      ERROR_CLEAR_IN <= 1'b0;
      #1;
      `CHK("cleared", 1'b0, PROTOCOL_ERROR_OUT)
   endtask

   // Readout read; counts words handed over and times the first one
   task automatic rd(input logic chop, input logic upper, input logic close,
                     input logic stall, input int words, input logic [15:0] pair);
      int first;
      int n;
      first = 0;
      n = 0;
      if (stall)
      begin
         @(posedge CLK_IN);
         u_ctrl_model.ready(1'b0);
      end
      u_ctrl_model.calib_read(chop, upper, close);
      for (int k = 1; k < 40; k++)
      begin
         #1;
         if (k == 1)
            `CHK("no array", 1'b0, ARRAY_REQ_OUT)
         if (stall && k == 19)
            `CHK("held", 1'b1, DQ_VALID_OUT)
         if (DQ_VALID_OUT === 1'b1 && DQ_READY_IN === 1'b1)
         begin
            if (first == 0)
               first = k;
            n++;
            `CHK("pair", pair, DQ_PAIR_OUT)
         end
         @(posedge CLK_IN);
         if (stall && k == 20)
            u_ctrl_model.ready(1'b1);
      end
      if (!stall)
         `CHK("latency", AL + CL, first)
      `CHK("words", words, n)
      `CHK("no error", 1'b0, PROTOCOL_ERROR_OUT)
   endtask

   task automatic t_reset();
      `CHK("open", 8'h00, BANK_OPEN_OUT)
      `CHK("idle", 8'hff, BANK_IDLE_OUT)
      `CHK("calib", 1'b0, CALIB_ACTIVE_OUT)
   endtask

   task automatic t_rows();
      cmd(ddr_calib_pkg::CMD_ACT, 3'h5, 14'h1234);
      `CHK("open", 8'h20, BANK_OPEN_OUT)
      cmd(ddr_calib_pkg::CMD_READ, 3'h5, 14'h12a5);
      `CHK("req", 1'b1, ARRAY_REQ_OUT)
      `CHK("row", 14'h1234, ARRAY_ROW_OUT)
      `CHK("col", 10'h2a5, ARRAY_COL_OUT)
      `CHK("read", 1'b0, ARRAY_WRITE_OUT)
      cmd(ddr_calib_pkg::CMD_WRITE, 3'h5, 14'h02a5);
      `CHK("write", 1'b1, ARRAY_WRITE_OUT)
      `CHK("chop", 1'b0, ARRAY_CHOP_OUT)
      cmd(ddr_calib_pkg::CMD_ACT, 3'h5, 14'h0001);
      `CHK("refused", 1'b1, PROTOCOL_ERROR_OUT)
      `CHK("pulse", 1'b0, ARRAY_REQ_OUT)
      clear_err();
      cmd(ddr_calib_pkg::CMD_ACT, 3'h6, 14'h0777);
      cmd(ddr_calib_pkg::CMD_READ, 3'h5, 14'h1400);
      cmd(ddr_calib_pkg::CMD_READ, 3'h6, 14'h1000);
      `CHK("bank", 3'h6, ARRAY_BANK_OUT)
      `CHK("row", 14'h0777, ARRAY_ROW_OUT)
      `CHK("open", 8'h40, BANK_OPEN_OUT)
      cmd(ddr_calib_pkg::CMD_PRE, 3'h5, 14'h0000);
      `CHK("no error", 1'b0, PROTOCOL_ERROR_OUT)
      cmd(ddr_calib_pkg::CMD_PRE, 3'h0, 14'h0400);
      `CHK("open", 8'h00, BANK_OPEN_OUT)
      repeat (2) @(posedge CLK_IN);
      #1;
      `CHK("idle", 8'hff, BANK_IDLE_OUT)
   endtask

   task automatic t_calib();
      // Burst field still at its reset value: fixed eight beats
      u_ctrl_model.enter();
      rd(1'b0, 1'b0, 1'b0, 1'b0, 4, 16'hff00);
      u_ctrl_model.leave();
      // Fixed chop overrides a high chop select
      cmd(ddr_calib_pkg::CMD_MRS, 3'h0, 14'h0002);
      u_ctrl_model.enter();
      rd(1'b0, 1'b0, 1'b0, 1'b0, 2, 16'hff00);
      u_ctrl_model.leave();
      cmd(ddr_calib_pkg::CMD_MRS, 3'h0, 14'h0001);
      u_ctrl_model.enter();
      `CHK("calib", 1'b1, CALIB_ACTIVE_OUT)
      // Repeated reads stand in for the capture-point sweep
      rd(1'b0, 1'b0, 1'b0, 1'b0, 4, 16'hff00);
      rd(1'b1, 1'b0, 1'b0, 1'b0, 2, 16'hff00);
      rd(1'b1, 1'b1, 1'b0, 1'b0, 2, 16'hff00);
      rd(1'b0, 1'b0, 1'b1, 1'b0, 4, 16'hff00);
      rd(1'b0, 1'b0, 1'b0, 1'b1, 4, 16'hff00);
      cmd(ddr_calib_pkg::CMD_WRITE, 3'h0, 14'h1000);
      `CHK("refused", 1'b1, PROTOCOL_ERROR_OUT)
      clear_err();
      cmd(ddr_calib_pkg::CMD_MRS, 3'h3, 14'h0005);
      repeat (u_ctrl_model.MODE_WAIT) @(posedge CLK_IN);
      rd(1'b0, 1'b0, 1'b0, 1'b0, 4, 16'h0000);
      u_ctrl_model.leave();
      #1;
      `CHK("calib", 1'b0, CALIB_ACTIVE_OUT)
      cmd(ddr_calib_pkg::CMD_ACT, 3'h1, 14'h0010);
      cmd(ddr_calib_pkg::CMD_READ, 3'h1, 14'h1000);
      `CHK("req", 1'b1, ARRAY_REQ_OUT)
      `CHK("bank", 3'h1, ARRAY_BANK_OUT)
      cmd(ddr_calib_pkg::CMD_READ, 3'h1, 14'h0000);
      `CHK("chop", 1'b1, ARRAY_CHOP_OUT)
   endtask

   initial
   begin
      CLK_IN = 1'b0;
      forever #20 CLK_IN = ~CLK_IN;
   end

   initial
   begin
      mismatches = 0;
      checks_done = 0;
      RST_N_IN = 1'b0;
      ERROR_CLEAR_IN = 1'b0;
      ADDITIVE_LATENCY_IN = 5'(AL);
      COLUMN_LATENCY_IN = 5'(CL);
      repeat (5) @(posedge CLK_IN);
      RST_N_IN <= 1'b1;
      #1;
      t_reset();
      t_rows();
      t_calib();
      give_verdict();
   end
endmodule // ddr_calib_readout_tb
